// File: inc/cscr_defs.svh
// offsets, field positions, reset values and masks of the channel sequence register bank
`ifndef CSCR_DEFS_SVH
`define CSCR_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CSCR_ADDR_TALLY 8'h08
`define CSCR_ADDR_SLOT_FIRST 8'h09
`define CSCR_ADDR_SLOT_LAST 8'h18

// ----------------------------------------------------------------
// slot configuration fields and reset values
// ----------------------------------------------------------------
`define CSCR_SLOT_EN_BIT 23
`define CSCR_SLOT_SETUP_HI 22
`define CSCR_SLOT_SETUP_LO 20
`define CSCR_SLOT_WATCH_BIT 18
`define CSCR_SLOT_PIN_HI 17
`define CSCR_SLOT_PIN_LO 13
`define CSCR_SLOT0_RESET 24'h800100
`define CSCR_SLOTN_RESET 24'h000100
`define CSCR_SLOT_WR_MASK 24'hF7E200
`define CSCR_TALLY_RESET 8'h00

`endif

// File: inc/cscr_pkg.sv
// types shared by the channel sequence register bank
package cscr_pkg;

    // ----------------------------------------------------------------
    // register port request
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [23:0] wdata;
        logic wr;
        logic rd;
    } cscr_req_s;

    // ----------------------------------------------------------------
    // conversion slot configuration word
    // ----------------------------------------------------------------
    typedef struct packed {
        logic enable;
        logic [2:0] setup_sel;
        logic spare_19;
        logic limit_watch_bit;
        logic [4:0] positive_input_select;
        logic [12:0] low_bits;
    } cscr_slot_s;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        SEQ_IDLE,
        SEQ_RUN
    } cscr_seq_e;

endpackage : cscr_pkg

// File: hw/cscr_seq_pick.sv
// picks the next enabled conversion slot above a given one, wrapping to the lowest
`timescale 1ns/1ps

module cscr_seq_pick import cscr_pkg::*; #(
    parameter int SLOTS = 16
) (
    // slot enables and current position
    input wire logic [SLOTS-1:0] slot_en,
    input wire logic [3:0] from_slot,
    // results
    output logic [3:0] next_slot,
    output logic [3:0] lowest_slot,
    output logic any_en
);

    // ----------------------------------------------------------------
    // priority scans
    // ----------------------------------------------------------------
    logic found_above;

    // scan downward so the last hit kept is the lowest index that qualifies
    always_comb begin
        next_slot = 4'h0;
        lowest_slot = 4'h0;
        any_en = 1'b0;
        found_above = 1'b0;
        for (int i = SLOTS - 1; i >= 0; i--) begin
            if (slot_en[i]) begin
                lowest_slot = 4'(i);
                any_en = 1'b1;
                if (4'(i) > from_slot) begin
                    next_slot = 4'(i);
                    found_above = 1'b1;
                end
            end
        end
        // nothing above the current slot: wrap round to the lowest
        if (!found_above) begin
            next_slot = lowest_slot;
        end
    end

endmodule : cscr_seq_pick

// File: hw/cscr_top.sv
// channel sequence register bank: slot configuration, clock tally and slot rotation
`timescale 1ns/1ps
`include "cscr_defs.svh"

// How it works
// - Address 0x08 reads an 8-bit clock tally that counts while counting is on and resets to zero.
// - Sixteen slot registers sit at 0x09 to 0x18, slot index being address minus 0x09.
// - Slot 0 resets to 0x800100 (enabled) and every other slot to 0x000100 (disabled).
// - Bit 23 of a slot register admits that slot to the automatic rotation when set.
// - The rotation starts at the lowest enabled slot, climbs through higher enabled slots and wraps.
// - Each written result loads its slot number into the low nibble of the status output.
// - Bits 22:20 pick one of eight setups for the slot, reset zero.
// - Slots may share a setup or use distinct ones; the selected setup is applied when converting.
// - Bit 18 flags the slot's results for limit checking, with no effect while the FIFO is off.
// - Bits 17:13 select the analog input for the slot's positive input, code 0 meaning input 0.

module cscr_top import cscr_pkg::*; #(
    parameter int SLOTS = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [23:0] reg_rdata,
    // tally enable pin, asynchronous to sys_clk
    input wire logic tally_enable_pin,
    // converter handshake and FIFO state
    input wire logic result_written,
    input wire logic fifo_enable,
    // current slot towards the converter
    output logic slot_valid,
    output logic [3:0] active_slot,
    output logic [2:0] active_setup,
    output logic [4:0] active_input,
    output logic active_limit_check,
    output logic [3:0] status_chan
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic is_slot_addr(input logic [7:0] a);
        return (a >= `CSCR_ADDR_SLOT_FIRST) && (a <= `CSCR_ADDR_SLOT_LAST);
    endfunction : is_slot_addr

    function automatic logic [3:0] slot_index(input logic [7:0] a);
        logic [7:0] d;
        d = a - `CSCR_ADDR_SLOT_FIRST;
        return d[3:0];
    endfunction : slot_index

    function automatic logic [23:0] slot_reset(input int idx);
        return (idx == 0) ? `CSCR_SLOT0_RESET : `CSCR_SLOTN_RESET;
    endfunction : slot_reset

    cscr_req_s req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // ----------------------------------------------------------------
    // tally enable synchroniser and clock tally
    // ----------------------------------------------------------------
    logic tally_sync_a;
    logic tally_sync_b;
    logic [7:0] tally;
    logic [7:0] next_tally;

    // two flops before any logic reads the pin
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tally_sync_a <= 1'b0;
            tally_sync_b <= 1'b0;
        end else begin
            tally_sync_a <= tally_enable_pin;
            tally_sync_b <= tally_sync_a;
        end
    end

    // counts system clocks while on; off clears it so a fresh run starts at zero
    always_comb begin
        next_tally = `CSCR_TALLY_RESET;
        if (tally_sync_b) begin
            next_tally = 8'(tally + 8'h01);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tally <= `CSCR_TALLY_RESET;
        end else begin
            tally <= next_tally;
        end
    end

    // ----------------------------------------------------------------
    // slot configuration registers
    // ----------------------------------------------------------------
    logic [23:0] slot_cfg [SLOTS];
    logic [23:0] next_slot_cfg [SLOTS];

    // only the documented fields and bit 9 take write data; the rest keep their reset pattern
    always_comb begin
        for (int i = 0; i < SLOTS; i++) begin
            next_slot_cfg[i] = slot_cfg[i];
        end
        if (req.wr && is_slot_addr(req.addr)) begin
            next_slot_cfg[slot_index(req.addr)] = (req.wdata & `CSCR_SLOT_WR_MASK) |
                (slot_reset(int'(slot_index(req.addr))) & ~`CSCR_SLOT_WR_MASK);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < SLOTS; i++) begin
                slot_cfg[i] <= slot_reset(i);
            end
        end else begin
            for (int i = 0; i < SLOTS; i++) begin
                slot_cfg[i] <= next_slot_cfg[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // read path: data stands only in the cycle after the strobe
    // ----------------------------------------------------------------
    logic [23:0] next_rdata;

    always_comb begin
        next_rdata = 24'h000000;
        if (req.rd) begin
            if (req.addr == `CSCR_ADDR_TALLY) begin
                next_rdata = {16'h0000, tally};
            end else if (is_slot_addr(req.addr)) begin
                next_rdata = slot_cfg[slot_index(req.addr)];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 24'h000000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // rotation through enabled slots
    // ----------------------------------------------------------------
    logic [SLOTS-1:0] slot_en;
    logic [3:0] pick_next;
    logic [3:0] pick_lowest;
    logic pick_any;
    cscr_seq_e seq_state;
    cscr_seq_e next_seq_state;
    logic [3:0] cur_slot;
    logic [3:0] next_cur_slot;
    logic [3:0] next_status_chan;

    // gather enable bits of every slot
    always_comb begin
        for (int i = 0; i < SLOTS; i++) begin
            slot_en[i] = slot_cfg[i][`CSCR_SLOT_EN_BIT];
        end
    end

    cscr_seq_pick #(
        .SLOTS(SLOTS)
    ) u_pick (
        .slot_en(slot_en),
        .from_slot(cur_slot),
        .next_slot(pick_next),
        .lowest_slot(pick_lowest),
        .any_en(pick_any)
    );

    // a slot disabled under the sequencer is left at once, so no stale slot is converted
    always_comb begin
        next_seq_state = seq_state;
        next_cur_slot = cur_slot;
        next_status_chan = status_chan;
        if (result_written) begin
            next_status_chan = cur_slot;
        end
        case (seq_state)
            SEQ_IDLE: begin
                if (pick_any) begin
                    next_seq_state = SEQ_RUN;
                    next_cur_slot = pick_lowest;
                end
            end
            SEQ_RUN: begin
                if (!pick_any) begin
                    next_seq_state = SEQ_IDLE;
                end else if (result_written || !slot_en[cur_slot]) begin
                    next_cur_slot = pick_next;
                end
            end
            default: begin
                next_seq_state = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            seq_state <= SEQ_IDLE;
            cur_slot <= 4'h0;
            status_chan <= 4'h0;
        end else begin
            seq_state <= next_seq_state;
            cur_slot <= next_cur_slot;
            status_chan <= next_status_chan;
        end
    end

    // ----------------------------------------------------------------
    // per-slot settings towards the converter
    // ----------------------------------------------------------------
    cscr_slot_s cur_cfg;
    assign cur_cfg = cscr_slot_s'(slot_cfg[cur_slot]);
    assign slot_valid = (seq_state == SEQ_RUN) && slot_en[cur_slot];
    assign active_slot = cur_slot;
    assign active_setup = cur_cfg.setup_sel;
    assign active_input = cur_cfg.positive_input_select;
    assign active_limit_check = cur_cfg.limit_watch_bit && fifo_enable;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // clock tally: counts while on, clears when off, reads back in the low byte
    a_tally_counts_on: assert property (tally_sync_b |=> tally == 8'($past(tally) + 8'h01))
        else $error("tally did not advance while enabled");
    a_tally_clears_off: assert property (!tally_sync_b |=> tally == 8'h00)
        else $error("tally not zero while disabled");
    a_tally_read_back: assert property (reg_rd && reg_addr == 8'h08 |=> reg_rdata == {16'h0000, $past(tally)})
        else $error("tally read returned wrong value");

    // ----------------------------------------------------------------
    // register port checks
    // ----------------------------------------------------------------
    // answers stand for one cycle only and holes in the map answer zero
    a_rdata_only_after: assert property (!reg_rd |=> reg_rdata == 24'h000000)
        else $error("read data outside the answer cycle");
    a_unmapped_reads: assert property (reg_rd && reg_addr != 8'h08 && (reg_addr < 8'h09 || reg_addr > 8'h18)
        |=> reg_rdata == 24'h000000)
        else $error("unmapped read returned data");
    a_slot_read_map: assert property (reg_rd && reg_addr == 8'h18 |=> reg_rdata == $past(slot_cfg[15]))
        else $error("last slot read returned wrong word");
    // a write lands only in the writable fields; the first slot has its own reset pattern
    a_slot_write_mask: assert property (reg_wr && reg_addr == 8'h0A |=>
        slot_cfg[1] == (($past(reg_wdata) & 24'hF7E200) | 24'h000100))
        else $error("slot 1 write did not keep reserved bits");
    a_first_slot_mask: assert property (reg_wr && reg_addr == 8'h09 |=>
        slot_cfg[0] == (($past(reg_wdata) & 24'hF7E200) | 24'h000100))
        else $error("slot 0 write did not keep reserved bits");
    // reserved bits never drift from their reset pattern, whatever software wrote
    a_reserved_first: assert property ((slot_cfg[0] & 24'h081DFF) == 24'h000100)
        else $error("slot 0 reserved bits changed");
    a_reserved_last: assert property ((slot_cfg[15] & 24'h081DFF) == 24'h000100)
        else $error("slot 15 reserved bits changed");

    // ----------------------------------------------------------------
    // rotation checks
    // ----------------------------------------------------------------
    // reset is sampled so the release edge, where the state is still forced, starts no attempt
    a_start_lowest: assert property (!sys_rst && seq_state == SEQ_IDLE && pick_any |=>
        seq_state == SEQ_RUN && cur_slot == $past(pick_lowest))
        else $error("rotation did not start at the lowest enabled slot");
    a_disabled_left: assert property (seq_state == SEQ_RUN && pick_any && !slot_en[cur_slot] |=>
        cur_slot == $past(pick_next))
        else $error("rotation stayed on a disabled slot");
    a_idle_without_en: assert property (!pick_any && !reg_wr |=> !slot_valid)
        else $error("slot valid with no slot enabled");
    a_seq_lands_enabled: assert property (result_written && seq_state == SEQ_RUN && pick_any && !reg_wr
        |=> slot_en[cur_slot] && seq_state == SEQ_RUN)
        else $error("rotation moved to a disabled slot");
    a_seq_order_wrap: assert property (result_written && seq_state == SEQ_RUN && !reg_wr
        |=> (cur_slot > $past(cur_slot)) || (cur_slot == pick_lowest))
        else $error("rotation out of ascending order");
    // the status nibble moves only on a written result
    a_status_tag: assert property (result_written |=> status_chan == $past(cur_slot))
        else $error("status nibble not loaded with converted slot");
    a_status_holds: assert property (!result_written |=> $stable(status_chan))
        else $error("status nibble changed without a result");

    // ----------------------------------------------------------------
    // converter-facing checks
    // ----------------------------------------------------------------
    // fields are checked by bit position, so a slip in the struct layout shows up here
    a_setup_mux: assert property (active_setup == slot_cfg[active_slot][22:20])
        else $error("setup select not taken from bits 22 to 20");
    a_input_mux: assert property (active_input == slot_cfg[active_slot][17:13])
        else $error("input select not taken from bits 17 to 13");
    a_limit_follow: assert property (fifo_enable |-> active_limit_check == slot_cfg[active_slot][18])
        else $error("limit check not taken from bit 18");
    a_limit_gate: assert property (!fifo_enable |-> !active_limit_check)
        else $error("limit check active with FIFO off");

endmodule : cscr_top

// File: verif/cscr_tb.sv
// self-checking testbench for the channel sequence register bank
`timescale 1ns/1ps
`include "cscr_defs.svh"

module testbench import cscr_pkg::*;;

    // ------------------------------
    // signals and notes
    // ------------------------------
    typedef struct packed {
        logic [3:0] status;
        logic [3:0] slot;
        logic [2:0] setup;
        logic [4:0] input_sel;
        logic limit;
        logic valid;
    } cscr_tb_seq_s;

    logic sys_clk, sys_rst, reg_wr, reg_rd, tally_enable_pin, result_written, fifo_enable;
    logic [7:0] reg_addr;
    logic [23:0] reg_wdata, reg_rdata, d, exp_rd;
    logic slot_valid, active_limit_check;
    logic [3:0] active_slot, status_chan, cur, nx;
    logic [2:0] active_setup;
    logic [4:0] active_input;
    logic rd_d1 = 1'b0;
    logic rw_d1 = 1'b0;
    int error_cnt = 0;
    int checked = 0;
    logic [23:0] rd_q[$];
    cscr_tb_seq_s seq_q[$];
    cscr_tb_seq_s exp_seq;
    logic [23:0] cfg [16];

    always #25 sys_clk = ~sys_clk;

    cscr_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tally_enable_pin(tally_enable_pin),
        .result_written(result_written), .fifo_enable(fifo_enable), .slot_valid(slot_valid),
        .active_slot(active_slot), .active_setup(active_setup), .active_input(active_input),
        .active_limit_check(active_limit_check), .status_chan(status_chan));

    // ------------------------------
    // helpers
    // ------------------------------
    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    // one port cycle; every strobe is assigned once per edge, so calls may follow back to back
    task automatic drv(input logic wr, input logic rd, input logic res, input logic [7:0] a, input logic [23:0] w);
        reg_wr <= wr;
        reg_rd <= rd;
        result_written <= res;
        reg_addr <= a;
        reg_wdata <= w;
        @(posedge sys_clk);
    endtask : drv

    task automatic rd(input logic [7:0] a, input logic [23:0] e);
        rd_q.push_back(e);
        drv(1'b0, 1'b1, 1'b0, a, 24'h000000);
    endtask : rd

    task automatic do_reset();
        // one quiet cycle first, so a read answer still in flight is compared before reset clears it
        drv(1'b0, 1'b0, 1'b0, 8'h00, 24'h000000);
        sys_rst <= 1'b1;
        repeat (4) drv(1'b0, 1'b0, 1'b0, 8'h00, 24'h000000);
        sys_rst <= 1'b0;
        drv(1'b0, 1'b0, 1'b0, 8'h00, 24'h000000);
    endtask : do_reset

    // read-back value: only the writable bits follow the data, the rest keep their reset level
    function automatic logic [23:0] slot_word(input int i, input logic [23:0] w);
        logic [23:0] r;
        r = (i == 0) ? `CSCR_SLOT0_RESET : `CSCR_SLOTN_RESET;
        return (w & `CSCR_SLOT_WR_MASK) | (r & ~`CSCR_SLOT_WR_MASK);
    endfunction : slot_word

    // next enabled slot above the current one, wrapping through 4-bit overflow
    function automatic logic [3:0] next_en(input logic [3:0] c);
        logic [3:0] k;
        k = c;
        for (int n = 0; n < 16; n++) begin
            k = k + 4'h1;
            if (cfg[k][23]) return k;
        end
        return c;
    endfunction : next_en

    // ------------------------------
    // monitor: oldest note against what appears
    // ------------------------------
    always @(posedge sys_clk) begin
        if (rd_d1) begin
            exp_rd = rd_q.pop_front();
            chk("reg_rdata", reg_rdata, exp_rd);
        end
        if (rw_d1) begin
            exp_seq = seq_q.pop_front();
            chk("sequencer outputs", {6'h00, status_chan, active_slot, active_setup, active_input,
                active_limit_check, slot_valid}, {6'h00, exp_seq});
        end
        rd_d1 <= reg_rd;
        rw_d1 <= result_written;
    end

    // hang guard, sized well above the roughly 560 cycles the tests take
    initial begin
        #(50 * 6000);
        error_cnt++;
        complete_run();
    end

    // ------------------------------
    // stimulus
    // ------------------------------
    initial begin
        sys_clk = 1'b0;
        sys_rst = 1'b1;
        {reg_wr, reg_rd, tally_enable_pin, result_written, fifo_enable} = 5'h00;
        reg_addr = 8'h00;
        reg_wdata = 24'h000000;
        void'($urandom(19));
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        drv(1'b0, 1'b0, 1'b0, 8'h00, 24'h000000);
        // reset values of every slot, then holes around the map
        for (int i = 0; i < 16; i++) rd(8'h09 + i[7:0], (i == 0) ? 24'h800100 : 24'h000100);
        rd(8'h00, 24'h000000);
        rd(8'h19, 24'h000000);
        rd(8'hFF, 24'h000000);
        // tally: read-only, counts while on, wraps at 8 bits, clears when off
        drv(1'b1, 1'b0, 1'b0, 8'h08, 24'hFFFFFF);
        rd(8'h08, 24'h000000);
        tally_enable_pin <= 1'b1;
        repeat (300) drv(1'b0, 1'b0, 1'b0, 8'h00, 24'h000000);
        rd(8'h08, 24'h00002A);
        rd(8'h08, 24'h00002B);
        tally_enable_pin <= 1'b0;
        repeat (5) drv(1'b0, 1'b0, 1'b0, 8'h00, 24'h000000);
        rd(8'h08, 24'h000000);
        // random words into every slot, each read straight back
        for (int i = 0; i < 16; i++) begin
            d = 24'($urandom);
            cfg[i] = slot_word(i, d);
            drv(1'b1, 1'b0, 1'b0, 8'h09 + i[7:0], d);
            rd(8'h09 + i[7:0], cfg[i]);
        end
        // rotation with random enables; pass 1 enables only the two end slots to stress the wrap
        for (int t = 0; t < 4; t++) begin
            do_reset();
            fifo_enable <= t[0];
            for (int i = 0; i < 16; i++) begin
                d = 24'($urandom);
                if (t == 1) d[23] = (i == 15);
                if (i == 0) d[23] = 1'b1;
                cfg[i] = slot_word(i, d);
                drv(1'b1, 1'b0, 1'b0, 8'h09 + i[7:0], d);
            end
            cur = 4'h0;
            repeat (20) begin
                nx = next_en(cur);
                seq_q.push_back({cur, nx, cfg[nx][22:20], cfg[nx][17:13], cfg[nx][18] & t[0], 1'b1});
                drv(1'b0, 1'b0, 1'b1, 8'h00, 24'h000000);
                cur = nx;
            end
            repeat (2) drv(1'b0, 1'b0, 1'b0, 8'h00, 24'h000000);
        end
        // no slot enabled: the rotation idles and a result only tags the status nibble
        do_reset();
        cfg[0] = slot_word(0, 24'h000000);
        drv(1'b1, 1'b0, 1'b0, 8'h09, 24'h000000);
        seq_q.push_back({4'h0, 4'h0, cfg[0][22:20], cfg[0][17:13], 1'b0, 1'b0});
        drv(1'b0, 1'b0, 1'b1, 8'h00, 24'h000000);
        // slot 5 starts the rotation; cleared under the sequencer it is left without a result
        drv(1'b1, 1'b0, 1'b0, 8'h0E, 24'h800000);
        drv(1'b1, 1'b0, 1'b0, 8'h09, 24'h800000);
        drv(1'b1, 1'b0, 1'b0, 8'h0E, 24'h000000);
        drv(1'b0, 1'b0, 1'b0, 8'h00, 24'h000000);
        seq_q.push_back({4'h0, 4'h0, 3'h0, 5'h00, 1'b0, 1'b1});
        drv(1'b0, 1'b0, 1'b1, 8'h00, 24'h000000);
        repeat (2) drv(1'b0, 1'b0, 1'b0, 8'h00, 24'h000000);
        chk("pending notes", 24'(rd_q.size() + seq_q.size()), 24'h000000);
        complete_run();
    end

endmodule : testbench
